// File: sim/scrg_board.sv
// board model: reset generator, straps and recovered lane clocks
`timescale 1ns/100ps
module scrg_board
    import scrg_pkg::*;
(
    // reference clock from the oscillator
    input  wire logic             mclk_i,
    // pins towards the device
    output logic                  hard_reset_n_o,
    output logic [OPT_W-1:0]      option_pins_o,
    output logic [LANES-1:0]      lane_clk_o
);
    // reset low from power-up, reference already running
    // test-port reset feeds the tap controller, outside this block
    initial begin
        hard_reset_n_o = 1'b0;
        option_pins_o = '0;
        lane_clk_o = '0;
    end

    // hold time scaled down, the 1 ms figure would dwarf the run;
    // an opt2 unlike opt breaks strap stability between the two samples
    task automatic hard_reset(input logic [OPT_W-1:0] opt, opt2);
        @(posedge mclk_i) #1;
        hard_reset_n_o = 1'b0;
        option_pins_o = opt;
        repeat (8) @(posedge mclk_i);
        #1 hard_reset_n_o = 1'b1;
        // the second sample sees the pins after the third edge
        repeat (3) @(posedge mclk_i);
        #1 option_pins_o = opt2;
        // straps held 20 cycles, then they drift away
        repeat (17) @(posedge mclk_i);
        #1 option_pins_o = ~opt2;
    endtask

    // lane clocks run only while a burst lasts, at a sixth of mclk so
    // every level is seen; edges stay clear of the mclk edges
    task automatic run_lanes(input int n);
        for (int i = 0; i < LANES; i++) begin
            repeat (2 * (n + i)) begin
                repeat (3) @(posedge mclk_i);
                #1 lane_clk_o[i] = ~lane_clk_o[i];
            end
        end
    endtask
endmodule // scrg_board

// File: sim/scrg_chk.sv
// port assertions for the clock and reset generator
`timescale 1ns/100ps
module scrg_chk
    import scrg_pkg::*;
(
    // clock, resets and board inputs
    input wire logic             mclk_i,
    input wire logic             rst_i,
    input wire logic             hard_reset_n_i,
    input wire logic [LANES-1:0] lane_clk_i,
    // watched outputs
    input wire logic             reg_en_o,
    input wire logic             fab_en_o,
    input wire logic             tx_en_o,
    input wire logic [LANES-1:0] lane_en_o,
    input wire logic             reg_rst_o,
    input wire logic             fab_rst_o,
    input wire logic             tx_rst_o,
    input wire logic             i2c_sclk_o,
    input wire logic             options_valid_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_rise; $rose(hard_reset_n_i) && fab_rst_o; endsequence
    sequence s_rel; s_rise ##1 hard_reset_n_i [*4]; endsequence
    property p_reg_run; !reg_rst_o && !reg_en_o |=> reg_en_o || reg_rst_o;
    endproperty
    a_reg_run: assert property (p_reg_run) else $error("reg gap");
    property p_fab_run; !fab_rst_o |-> fab_en_o; endproperty
    a_fab_run: assert property (p_fab_run) else $error("fab en");
    property p_tx; tx_en_o == fab_en_o && tx_rst_o == fab_rst_o; endproperty
    a_tx: assert property (p_tx) else $error("tx domain");
    property p_hold; s_rise |=> fab_rst_o [*4]; endproperty
    a_hold: assert property (p_hold) else $error("early release");
    property p_release; s_rel |=> !fab_rst_o; endproperty
    a_release: assert property (p_release) else $error("late release");
    property p_reg_rel; $fell(reg_rst_o) |-> $past(reg_en_o) && !fab_rst_o;
    endproperty
    a_reg_rel: assert property (p_reg_rel) else $error("reg rst");
    property p_opt; $rose(options_valid_o) |-> $past(fab_rst_o, 2)
        && !$past(fab_rst_o); endproperty
    a_opt: assert property (p_opt) else $error("strap time");
    property p_lane; lane_en_o[0] |-> $past(lane_clk_i[0], 3)
        && !$past(lane_clk_i[0], 4); endproperty
    a_lane: assert property (p_lane) else $error("lane en");
    property p_sclk; !reg_rst_o && $changed(i2c_sclk_o) |-> $past(reg_en_o);
    endproperty
    a_sclk: assert property (p_sclk) else $error("sclk step");
endmodule // scrg_chk

bind scrg_top scrg_chk u_chk (
    .mclk_i          (mclk_i),
    .rst_i           (rst_i),
    .hard_reset_n_i  (hard_reset_n_i),
    .lane_clk_i      (lane_clk_i),
    .reg_en_o        (reg_en_o),
    .fab_en_o        (fab_en_o),
    .tx_en_o         (tx_en_o),
    .lane_en_o       (lane_en_o),
    .reg_rst_o       (reg_rst_o),
    .fab_rst_o       (fab_rst_o),
    .tx_rst_o        (tx_rst_o),
    .i2c_sclk_o      (i2c_sclk_o),
    .options_valid_o (options_valid_o)
);

// File: sim/testbench.sv
// self-checking bench for the clock and reset generator
`timescale 1ns/100ps
module testbench;
    import scrg_pkg::*;
    logic             mclk_i = 1'b0;
    logic             rst_i = 1'b1;
    logic             hard_reset_n_i;
    logic [OPT_W-1:0] option_pins_i, options_o;
    logic [DIV_W-1:0] i2c_div_i = '0;
    logic             i2c_div_load_i = 1'b0;
    logic [LANES-1:0] lane_clk_i, lane_en_o, lane_rst_o;
    logic             reg_en_o, fab_en_o, tx_en_o, reg_rst_o, fab_rst_o;
    logic             tx_rst_o, i2c_sclk_o, i2c_tick_o;
    logic             options_valid_o, options_mismatch_o;
    int               n_mismatch = 0;
    int               compares = 0;
    int               ticks = 0;
    int               lanes [LANES] = '{default: 0};

    scrg_top dut (
        .mclk_i             (mclk_i),
        .rst_i              (rst_i),
        .hard_reset_n_i     (hard_reset_n_i),
        .option_pins_i      (option_pins_i),
        .i2c_div_i          (i2c_div_i),
        .i2c_div_load_i     (i2c_div_load_i),
        .lane_clk_i         (lane_clk_i),
        .reg_en_o           (reg_en_o),
        .fab_en_o           (fab_en_o),
        .tx_en_o            (tx_en_o),
        .lane_en_o          (lane_en_o),
        .reg_rst_o          (reg_rst_o),
        .fab_rst_o          (fab_rst_o),
        .tx_rst_o           (tx_rst_o),
        .lane_rst_o         (lane_rst_o),
        .i2c_sclk_o         (i2c_sclk_o),
        .i2c_tick_o         (i2c_tick_o),
        .options_o          (options_o),
        .options_valid_o    (options_valid_o),
        .options_mismatch_o (options_mismatch_o)
    );
    scrg_board board (
        .mclk_i         (mclk_i),
        .hard_reset_n_o (hard_reset_n_i),
        .option_pins_o  (option_pins_i),
        .lane_clk_o     (lane_clk_i)
    );

    always #2.5 mclk_i = ~mclk_i;

    always @(posedge mclk_i) begin
        ticks <= ticks + int'(i2c_tick_o);
        for (int i = 0; i < LANES; i++) begin
            lanes[i] <= lanes[i] + int'(lane_en_o[i]);
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // later pin changes must not reach the latched straps
    task automatic t_straps(input logic [OPT_W-1:0] opt, opt2);
        logic [2:0] st;
        st = {1'b1, opt != opt2, 1'b0};
        board.hard_reset(opt, opt2);
        chk(options_o, opt2);
        chk({options_valid_o, options_mismatch_o, fab_rst_o}, st);
        chk(lane_rst_o, 4'hf);
        repeat (4) @(posedge mclk_i);
        chk(options_o, opt2);
    endtask

    // period in mclk cycles, skipping one sclk period still on old value
    task automatic measure(input int exp);
        longint t0;
        int     k;
        repeat (2) @(posedge i2c_sclk_o);
        #1 t0 = $time;
        k = ticks;
        @(posedge i2c_sclk_o) #1;
        chk(32'(($time - t0) / 5), exp);
        chk(ticks - k, 1);
    endtask

    task automatic t_div(input logic [DIV_W-1:0] a, b, input int exp);
        @(posedge mclk_i) #1;
        i2c_div_i = a;
        i2c_div_load_i = 1'b1;
        @(posedge mclk_i) #1;
        i2c_div_i = b;
        @(posedge mclk_i) #1;
        i2c_div_load_i = 1'b0;
        measure(exp);
    endtask

    task automatic t_lane(input int n);
        int base [LANES];
        base = lanes;
        board.run_lanes(n);
        repeat (6) @(posedge mclk_i);
        for (int i = 0; i < LANES; i++) begin
            chk(lanes[i] - base[i], n + i);
        end
        chk(lane_rst_o, '0);
    endtask

    initial begin
        repeat (6) @(posedge mclk_i);
        #1;
        chk({fab_rst_o, reg_rst_o, reg_en_o, options_valid_o}, 4'hc);
        rst_i = 1'b0;
        t_straps(8'ha5, 8'ha5);
        measure(1564);
        t_div(16'h0004, 16'h0004, 8);
        t_div(16'h0001, 16'h0001, 4);
        t_div(16'h0000, 16'h0000, 4);
        t_div(16'h0005, 16'h0005, 10);
        t_div(16'h0009, 16'h0006, 12);
        t_lane(3);
        t_straps(8'h0f, 8'hf0);
        t_straps(8'h3c, 8'h3c);
        t_lane(2);
        stop_test();
    end

    initial begin
        repeat (40000) @(posedge mclk_i);
        n_mismatch++;
        stop_test();
    end
endmodule // testbench

// File: src/scrg_pkg.sv
// shared constants for the switch clock and reset generator
package scrg_pkg;
    // number of serial lanes with their own recovered clock
    localparam int unsigned LANES      = 4;
    // width of the power-up option pin group
    localparam int unsigned OPT_W      = 8;
    // width of the two-wire bus clock divisor
    localparam int unsigned DIV_W      = 16;
    // divisor after reset, 782: 100 kHz from a 156.25 MHz reference
    localparam logic [DIV_W-1:0] I2C_DIV_RST = 16'h030e;
    // smallest divisor that still gives a low and a high phase
    localparam logic [DIV_W-1:0] I2C_DIV_MIN = 16'h0002;
    // register-bus domain runs at the reference divided by this plus one
    localparam logic [0:0] REG_DIV_LAST = 1'h1;
    // synchroniser depth after the two metastability flops
    localparam int unsigned REL_STAGES = 2;
endpackage : scrg_pkg

// File: src/scrg_rst_if.sv
// reset release and option sample bundle between synchroniser and top
`timescale 1ns/100ps
interface scrg_rst_if;
    import scrg_pkg::*;
    logic             in_reset;
    logic [OPT_W-1:0] options;
    logic             opt_valid;
    logic             opt_mismatch;

    modport sync (output in_reset, output options, output opt_valid,
                  output opt_mismatch);
    modport user (input in_reset, input options, input opt_valid,
                  input opt_mismatch);
endinterface : scrg_rst_if

// File: src/scrg_rst_sync.sv
// hard reset synchroniser and power-up option double sampler
`timescale 1ns/100ps
module scrg_rst_sync
    import scrg_pkg::*;
(
    // clock and power-on reset
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    // board pins
    input  wire logic             hard_reset_n_i,
    input  wire logic [OPT_W-1:0] option_pins_i,
    // bundle towards the top
    scrg_rst_if.sync              rel
);
    logic [1:0]            hr_meta_q;
    logic [REL_STAGES-1:0] hr_pipe_q;
    logic [OPT_W-1:0]      opt_m0_q;
    logic [OPT_W-1:0]      opt_m1_q;
    logic [OPT_W-1:0]      opt_first_q;
    logic                  rel_d1_q;
    logic                  released;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            hr_meta_q <= 2'h0;
            hr_pipe_q <= '0;
        end else begin
            hr_meta_q <= {hr_meta_q[0], hard_reset_n_i};
            hr_pipe_q <= {hr_pipe_q[REL_STAGES-2:0], hr_meta_q[1]};
        end
    end

    // option pins pass only two flops, half the four-flop depth of the release path
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            opt_m0_q <= '0;
            opt_m1_q <= '0;
        end else begin
            opt_m0_q <= option_pins_i;
            opt_m1_q <= opt_m0_q;
        end
    end

    assign released    = hr_pipe_q[REL_STAGES-1];
    assign rel.in_reset = ~released;

    always_ff @(posedge mclk_i) begin
        if (rst_i || !released) begin
            rel_d1_q         <= 1'h0;
            opt_first_q      <= '0;
            rel.options      <= '0;
            rel.opt_valid    <= 1'h0;
            rel.opt_mismatch <= 1'h0;
        end else begin
            rel_d1_q <= 1'h1;
            if (!rel_d1_q) begin
                opt_first_q <= opt_m1_q;
            end
            if (rel_d1_q && !rel.opt_valid) begin
                rel.options      <= opt_m1_q;
                rel.opt_valid    <= 1'h1;
                rel.opt_mismatch <= (opt_m1_q != opt_first_q);
            end
        end
    end
endmodule : scrg_rst_sync

// File: src/scrg_top.sv
// clock-domain enables and reset release for the serial packet switch
//
// Notes on behaviour
// - register bus and its master/slave parts run at reference divided by two.
// - switch_fabric and multicast engine run at the reference rate undivided.
// - each received lane gets its own recovered clock domain at its baud rate.
// - transmit logic runs from reference; serializer clock derived; 3.125 Gbps max.
// - two-wire clock is halved reference divided by programmable value, 782 default.
// - two-wire controller mostly in register domain; only clock output divided.
// - hard reset release passes reference-clock synchronisers governing internal release.
// - non-power-cycle hard resets need no test-port reset; device tolerates that.
// - option pins sampled twice at release; stable at release, no setup.
`timescale 1ns/100ps
module scrg_top
    import scrg_pkg::*;
(
    // reference clock and power-on reset
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    // board reset and straps
    input  wire logic             hard_reset_n_i,
    input  wire logic [OPT_W-1:0] option_pins_i,
    // two-wire clock divisor from the controller
    input  wire logic [DIV_W-1:0] i2c_div_i,
    input  wire logic             i2c_div_load_i,
    // recovered lane clocks, sampled as levels
    input  wire logic [LANES-1:0] lane_clk_i,
    // domain enables
    output logic                  reg_en_o,
    output logic                  fab_en_o,
    output logic                  tx_en_o,
    output logic [LANES-1:0]      lane_en_o,
    // domain resets, active high
    output logic                  reg_rst_o,
    output logic                  fab_rst_o,
    output logic                  tx_rst_o,
    output logic [LANES-1:0]      lane_rst_o,
    // two-wire bus clock
    output logic                  i2c_sclk_o,
    output logic                  i2c_tick_o,
    // latched straps
    output logic [OPT_W-1:0]      options_o,
    output logic                  options_valid_o,
    output logic                  options_mismatch_o
);
    scrg_rst_if rel ();

    // divider and lane synchroniser state
    logic [0:0]       half_q;
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_cnt_q;
    logic [DIV_W-1:0] div_half;
    logic [DIV_W-1:0] div_load;
    logic [DIV_W-1:0] div_last;
    logic [DIV_W-1:0] div_cnt_nx;
    logic [LANES-1:0] lane_m0_q;
    logic [LANES-1:0] lane_m1_q;
    logic [LANES-1:0] lane_prev_q;
    logic [LANES-1:0] lane_edge;

    // no test-port reset input is needed
    // a warm hard reset alone restarts every domain cleanly
    scrg_rst_sync u_sync (
        .mclk_i         (mclk_i),
        .rst_i          (rst_i),
        .hard_reset_n_i (hard_reset_n_i),
        .option_pins_i  (option_pins_i),
        .rel            (rel)
    );

    assign options_o          = rel.options;
    assign options_valid_o    = rel.opt_valid;
    assign options_mismatch_o = rel.opt_mismatch;

    // halved reference
    // the phase restarts at each release so reg_en_o has a fixed offset
    always_ff @(posedge mclk_i) begin
        if (rst_i || rel.in_reset) begin
            half_q   <= 1'h0;
            reg_en_o <= 1'h0;
        end else begin
            half_q   <= (half_q == REG_DIV_LAST) ? 1'h0 : half_q + 1'h1;
            reg_en_o <= (half_q == REG_DIV_LAST);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i || rel.in_reset) begin
            fab_en_o <= 1'h0;
        end else begin
            fab_en_o <= 1'h1;
        end
    end

    // transmit logic runs every reference cycle; the serializer
    // clock comes from the analog side and is not built here
    always_ff @(posedge mclk_i) begin
        if (rst_i || rel.in_reset) begin
            tx_en_o <= 1'h0;
        end else begin
            tx_en_o <= 1'h1;
        end
    end

    // fabric leaves reset right after synced release
    // hard reset low holds every domain; only the divisor keeps its value
    always_ff @(posedge mclk_i) begin
        if (rst_i || rel.in_reset) begin
            fab_rst_o <= 1'h1;
        end else begin
            fab_rst_o <= 1'h0;
        end
    end

    // transmit side leaves reset in step with the fabric
    always_ff @(posedge mclk_i) begin
        if (rst_i || rel.in_reset) begin
            tx_rst_o <= 1'h1;
        end else begin
            tx_rst_o <= 1'h0;
        end
    end

    // register domain released on its own enable
    always_ff @(posedge mclk_i) begin
        if (rst_i || rel.in_reset) begin
            reg_rst_o <= 1'h1;
        end else if (reg_en_o) begin
            reg_rst_o <= 1'h0;
        end
    end

    // divisor is loaded on any reference cycle with the load strobe, not on reg_en_o; tiny values are clamped
    // so the output never sticks at one level
    always_comb begin
        div_load = i2c_div_i;
        if (i2c_div_i < I2C_DIV_MIN) begin
            div_load = I2C_DIV_MIN;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            div_q <= I2C_DIV_RST;
        end else if (i2c_div_load_i) begin
            div_q <= div_load;
        end
    end

    assign div_half   = div_q >> 1;
    assign div_last   = div_q - 16'h0001;
    assign div_cnt_nx = div_cnt_q + 16'h0001;

    // divide halved reference; only this runs on the divided rate
    // a new divisor acts at the next compare; a count past it wraps at once
    always_ff @(posedge mclk_i) begin
        if (rst_i || reg_rst_o) begin
            div_cnt_q  <= '0;
            i2c_sclk_o <= 1'h0;
            i2c_tick_o <= 1'h0;
        end else begin
            i2c_tick_o <= 1'h0;
            if (reg_en_o) begin
                if (div_cnt_q >= div_last) begin
                    div_cnt_q  <= '0;
                    i2c_sclk_o <= 1'h0;
                    i2c_tick_o <= 1'h1;
                end else begin
                    div_cnt_q  <= div_cnt_nx;
                    i2c_sclk_o <= (div_cnt_nx >= div_half);
                end
            end
        end
    end

    // per-lane recovered clock, two flops then edge detect
    // lane clocks must stay below half the reference to be seen as levels
    generate
        for (genvar g = 0; g < LANES; g++) begin : g_lane
            // third flop only holds the previous level for edge detection
            always_ff @(posedge mclk_i) begin
                if (rst_i) begin
                    lane_m0_q[g]   <= 1'h0;
                    lane_m1_q[g]   <= 1'h0;
                    lane_prev_q[g] <= 1'h0;
                end else begin
                    lane_m0_q[g]   <= lane_clk_i[g];
                    lane_m1_q[g]   <= lane_m0_q[g];
                    lane_prev_q[g] <= lane_m1_q[g];
                end
            end

            // prev starts low, the idle level of a lane, so no false edge
            assign lane_edge[g] = lane_m1_q[g] & ~lane_prev_q[g];

            always_ff @(posedge mclk_i) begin
                if (rst_i || rel.in_reset) begin
                    lane_en_o[g] <= 1'h0;
                end else begin
                    lane_en_o[g] <= lane_edge[g];
                end
            end

            // a lane leaves reset on its own first recovered edge
            // a lane that never toggles stays in reset on purpose
            always_ff @(posedge mclk_i) begin
                if (rst_i || rel.in_reset) begin
                    lane_rst_o[g] <= 1'h1;
                end else if (lane_edge[g]) begin
                    lane_rst_o[g] <= 1'h0;
                end
            end
        end
    endgenerate
endmodule : scrg_top
